// [tb_video_luma_bcs_sync_path.sv]
`timescale 1ns/100ps
module tb_video_luma_bcs_sync_path;
	import vlb_pkg::*;
	logic        i_mclk, i_rst, ce, sup, cko, rd_s, wr_s;
	logic        out_oe_n, line_locked_clock, line_locked_half_clock, clk_oe_n, sd_oe_n, rst_ind, lfc, wreq;
	logic [7:0]  addr, con, bri, sat, rg, ro, cbv, crv, sb0, sb1;
	logic [8:0]  cv;
	logic [31:0] wdat, rdat, got, s_last, lcw;
	vlb_in_t     din;
	vlb_out_t    dout;
	int          s_cnt, error_cnt, n_tests, seed, p50, p60, na, nb, c0, n;

	vlb_luma_path dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_in(din),
		.i_remod_sub0(sb0), .i_remod_sub1(sb1), .i_chip_enable(ce),
		.i_supply_ok(sup), .i_clock_ok(cko), .i_avs_address(addr), .i_avs_read(rd_s),
		.i_avs_write(wr_s), .i_avs_writedata(wdat), .o_avs_readdata(rdat),
		.o_avs_waitrequest(wreq), .o_out(dout), .o_out_oe_n(out_oe_n),
		.o_line_locked_clock(line_locked_clock), .o_line_locked_half_clock(line_locked_half_clock),
		.o_clk_oe_n(clk_oe_n), .o_decoder_serial_data_oe_n(sd_oe_n),
		.o_reset_indicator_out(rst_ind), .o_line_freq_control(lfc));
	vlb_sink sink (.i_mclk(i_mclk), .i_rst(i_rst), .i_out(dout), .i_oe_n(out_oe_n),
		.o_last(s_last), .o_cnt(s_cnt));

	initial begin
		i_mclk = 1'b0;
		forever #2.5 i_mclk = ~i_mclk;
	end
	always @(posedge line_locked_clock) na++;
	always @(posedge line_locked_half_clock) nb++;

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] val);
		n_tests++;
		if (val !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, val);
		end
	endtask

	task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int k;
		k = 0;
		addr <= a;
		wdat <= wd;
		wr_s <= wr;
		rd_s <= !wr;
		@(posedge i_mclk);
		while (wreq !== 1'b0 && k < 50) begin
			@(posedge i_mclk);
			k++;
		end
		got = rdat;
		if (k >= 50) chk("bus answer", 32'h0, 32'h1);
		rd_s <= 1'b0;
		wr_s <= 1'b0;
		@(posedge i_mclk);
	endtask

	// Truncating divide first, then offset, then clip
	function automatic logic [7:0] lvl(int g, int dv, int x, int off);
		int v;
		v = (g * (x - MID)) / dv + off;
		if (v < CLIP_MIN) v = CLIP_MIN;
		if (v > CLIP_MAX) v = CLIP_MAX;
		return v[7:0];
	endfunction

	task wait_lfc(input logic v);
		while (lfc !== v && n < 40000) begin
			@(posedge i_mclk);
			n++;
		end
	endtask

	task final_report;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		#(5 * 60000);
		error_cnt++;
		$display("watchdog expired");
		final_report;
	end

	initial begin
		seed = 26731;
		error_cnt = 0;
		n_tests = 0;
		i_rst = 1'b1;
		{ce, sup, cko, rd_s, wr_s} = 5'b11100;
		addr = 8'h00;
		wdat = 32'h0;
		{sb0, sb1} = 16'h8080;
		din = '0;
		repeat (3) @(posedge i_mclk);
		chk("ind in reset", 32'h0, rst_ind);
		chk("oe in reset", 32'h7, {out_oe_n, clk_oe_n, sd_oe_n});
		i_rst <= 1'b0;
		repeat (10) @(posedge i_mclk);
		chk("ind hold", 32'h0, rst_ind);
		bus(1'b0, OFF_BCS, 32'h0);
		chk("bcs default", 32'h00408044, got);
		bus(1'b0, OFF_RAW, 32'h0);
		chk("raw default", 32'h00008040, got);
		bus(1'b0, OFF_ID, 32'h0);
		chk("id", {24'h0, ID_VALUE}, got);
		bus(1'b0, 8'hf0, 32'h0);
		chk("unmapped", 32'h0, got);
		repeat (1500) @(posedge i_mclk);
		chk("ind released", 32'h1, rst_ind);
		chk("oe after reset", 32'h4, {out_oe_n, clk_oe_n, sd_oe_n});
		bus(1'b1, OFF_OUT_EN, 32'h1);
		@(posedge i_mclk);
		chk("out enabled", 32'h0, out_oe_n);
		$display("test reset done");
		for (int i = 0; i < 24; i++) begin
			{con, bri, sat, rg, ro} = {$random(seed), $random(seed)};
			{cv, cbv, crv} = $random(seed);
			if (i == 0) {con, bri, sat, rg, ro} = 40'h4480404080;
			if (i == 1) {con, bri, sat, rg, ro, cv, cbv, crv} = {40'hffffffffff, 25'h1ffff00};
			if (i == 2) {con, bri, sat, rg, ro, cv, cbv, crv} = {40'hff00ff0000, 25'h00000ff};
			bus(1'b1, OFF_BCS, {8'h0, sat, bri, con});
			bus(1'b1, OFF_RAW, {16'h0, ro, rg});
			lcw = {25'h0, i[0], 1'b0, i[1], 4'h0};
			bus(1'b1, OFF_LUMA_CTRL, lcw);
			bus(1'b0, OFF_LUMA_CTRL, 32'h0);
			chk("luma ctrl", lcw, got);
			bus(1'b1, OFF_LUMA_DELAY, {29'h0, i[4:2]});
			bus(1'b0, OFF_LUMA_DELAY, 32'h0);
			chk("delay", {29'h0, i[4:2]}, got);
			// Comb on: luma must ignore the subcarrier entirely
			{sb0, sb1} <= i[0] ? 16'($random(seed)) : 16'h8080;
			c0 = s_cnt;
			din <= '{cvbs: cv, cb: cbv, cr: crv, valid: 1'b1};
			repeat (16) @(posedge i_mclk);
			din.valid <= 1'b0;
			repeat (4) @(posedge i_mclk);
			chk("samples", 32'd16, s_cnt - c0);
			chk("y", lvl(con, CON_DIV, cv[8:1], bri), s_last[31:24]);
			chk("cb", lvl(sat, SAT_DIV, cbv, MID), s_last[23:16]);
			chk("cr", lvl(sat, SAT_DIV, crv, MID), s_last[15:8]);
			chk("raw", lvl(rg, SAT_DIV, cv[8:1], ro), s_last[7:0]);
		end
		$display("test levels done");
		for (int m = 0; m < 2; m++) begin
			bus(1'b1, OFF_CHROMA_STD, {31'h0, m[0]});
			n = 0;
			wait_lfc(1'b0);
			wait_lfc(1'b1);
			n = 0;
			wait_lfc(1'b0);
			wait_lfc(1'b1);
			if (m == 0) p50 = n;
			else p60 = n;
		end
		chk("line ratio", p50 * LINE_60, p60 * LINE_50);
		na = 0;
		nb = 0;
		repeat (1400) @(posedge i_mclk);
		chk("half rate", 32'h1, (na - 2 * nb <= 2 && 2 * nb - na <= 2 && nb > 10));
		$display("test clocks done");
		for (int j = 0; j < 3; j++) begin
			bus(1'b1, OFF_BCS, 32'h00112233);
			{ce, sup, cko} <= ~(3'b100 >> j);
			repeat (10) @(posedge i_mclk);
			chk("ind off", 32'h0, rst_ind);
			chk("oe off", 32'h7, {out_oe_n, clk_oe_n, sd_oe_n});
			{ce, sup, cko} <= 3'b111;
			repeat (40) @(posedge i_mclk);
			chk("oe back", 32'h4, {out_oe_n, clk_oe_n, sd_oe_n});
			bus(1'b0, OFF_BCS, 32'h0);
			chk("bcs reload", 32'h00408044, got);
			bus(1'b0, OFF_STATUS, 32'h0);
			chk("status clear", 32'h0, got);
		end
		$display("test enable done");
		final_report;
	end
endmodule

// [vlb_luma_path.sv]
`timescale 1ns/100ps
module vlb_luma_path (
	input  wire logic           i_mclk,
	input  wire logic           i_rst,
	input  wire vlb_pkg::vlb_in_t i_in,
	input  wire logic [7:0]     i_remod_sub0,
	input  wire logic [7:0]     i_remod_sub1,
	input  wire logic           i_chip_enable,
	input  wire logic           i_supply_ok,
	input  wire logic           i_clock_ok,
	input  wire logic [7:0]     i_avs_address,
	input  wire logic           i_avs_read,
	input  wire logic           i_avs_write,
	input  wire logic [31:0]    i_avs_writedata,
	output logic [31:0]         o_avs_readdata,
	output logic                o_avs_waitrequest,
	output vlb_pkg::vlb_out_t   o_out,
	output logic                o_out_oe_n,
	output logic                o_line_locked_clock,
	output logic                o_line_locked_half_clock,
	output logic                o_clk_oe_n,
	output logic                o_decoder_serial_data_oe_n,
	output logic                o_reset_indicator_out,
	output logic                o_line_freq_control
);
	import vlb_pkg::*;

	// Reset and enable synchronisers
	logic [1:0] ce_sync, sup_sync, clk_sync;
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			ce_sync  <= 2'b00;
			sup_sync <= 2'b00;
			clk_sync <= 2'b00;
		end else begin
			ce_sync  <= {ce_sync[0], i_chip_enable};
			sup_sync <= {sup_sync[0], i_supply_ok};
			clk_sync <= {clk_sync[0], i_clock_ok};
		end
	end
	wire int_reset = !ce_sync[1] || !sup_sync[1] || !clk_sync[1];

	// Line-locked clock divider
	logic [3:0] llc_cnt;
	logic [1:0] llc_ph;
	wire llc_tick = (llc_cnt == 4'(LLC_DIV / 2 - 1));
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			llc_cnt <= 4'h0;
			llc_ph  <= 2'h0;
		end else if (llc_tick) begin
			llc_cnt <= 4'h0;
			llc_ph  <= llc_ph + 2'h1;
		end else begin
			llc_cnt <= llc_cnt + 4'h1;
		end
	end
	wire llc_rise = llc_tick && llc_ph[0];
	wire ll4_rise = llc_tick && (llc_ph == 2'h3);

	// Reset sequencer
	vlb_rst_state_t rs_state, next_rs_state;
	logic [7:0] hold_cnt;
	wire hold_done = (hold_cnt == 8'(RESET_LLC - 1));
	always_comb begin
		next_rs_state = rs_state;
		case (rs_state)
			RS_RESET: next_rs_state = int_reset ? RS_RESET : RS_HOLD;
			RS_HOLD:  next_rs_state = int_reset ? RS_RESET : ((hold_done && llc_rise) ? RS_RUN : RS_HOLD);
			RS_RUN:   next_rs_state = int_reset ? RS_RESET : RS_RUN;
			default:  next_rs_state = RS_RESET;
		endcase
	end
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			rs_state <= RS_RESET;
			hold_cnt <= 8'h00;
		end else begin
			rs_state <= next_rs_state;
			if (rs_state != RS_HOLD)
				hold_cnt <= 8'h00;
			else if (llc_rise)
				hold_cnt <= hold_cnt + 8'h01;
		end
	end
	wire soft_rst = (rs_state == RS_RESET);

	// Registers
	logic [7:0] luma_ctrl, chroma_std, luma_delay_reg, out_en;
	logic [7:0] contrast_gain, brightness_offset, saturation_gain, raw_gain, raw_offset;
	logic       copy_protect_flag, sync_locked;
	// Write lands only on the edge that ends the wait
	wire wr = i_avs_write && !o_avs_waitrequest && !soft_rst;
	wire sel_luma = (i_avs_address == OFF_LUMA_CTRL);
	wire sel_std  = (i_avs_address == OFF_CHROMA_STD);
	wire sel_dly  = (i_avs_address == OFF_LUMA_DELAY);
	wire sel_stat = (i_avs_address == OFF_STATUS);
	wire sel_bcs  = (i_avs_address == OFF_BCS);
	wire sel_raw  = (i_avs_address == OFF_RAW);
	wire sel_oen  = (i_avs_address == OFF_OUT_EN);
	wire sel_id   = (i_avs_address == OFF_ID);
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			luma_ctrl         <= 8'h00;
			chroma_std        <= 8'h00;
			luma_delay_reg    <= 8'h00;
			out_en            <= 8'h00;
			contrast_gain     <= RST_CONTRAST;
			brightness_offset <= RST_BRIGHT;
			saturation_gain   <= RST_SAT;
			raw_gain          <= RST_RAW_GAIN;
			raw_offset        <= RST_RAW_OFFSET;
		end else if (soft_rst) begin
			luma_ctrl         <= 8'h00;
			chroma_std        <= 8'h00;
			luma_delay_reg    <= 8'h00;
			out_en            <= 8'h00;
			contrast_gain     <= RST_CONTRAST;
			brightness_offset <= RST_BRIGHT;
			saturation_gain   <= RST_SAT;
			raw_gain          <= RST_RAW_GAIN;
			raw_offset        <= RST_RAW_OFFSET;
		end else if (wr) begin
			if (sel_luma) luma_ctrl <= i_avs_writedata[7:0];
			if (sel_std)  chroma_std <= i_avs_writedata[7:0];
			if (sel_dly)  luma_delay_reg <= {5'h00, i_avs_writedata[2:0]};
			if (sel_oen)  out_en <= {7'h00, i_avs_writedata[0]};
			if (sel_bcs) begin
				contrast_gain     <= i_avs_writedata[7:0];
				brightness_offset <= i_avs_writedata[15:8];
				saturation_gain   <= i_avs_writedata[23:16];
			end
			if (sel_raw) begin
				raw_gain   <= i_avs_writedata[7:0];
				raw_offset <= i_avs_writedata[15:8];
			end
		end
	end
	wire luma_comb_enable   = luma_ctrl[POS_COMB];
	wire notch_width_select = luma_ctrl[POS_NOTCH];
	wire [3:0] luma_filter_select = luma_ctrl[3:0];
	wire [2:0] luma_delay_select  = luma_delay_reg[2:0];
	wire std_60hz = chroma_std[0];
	wire [7:0] status_byte = {5'h00, copy_protect_flag, 1'b0, sync_locked};
	wire [31:0] rd_mux =
		sel_luma ? {24'h0, luma_ctrl} :
		sel_std  ? {24'h0, chroma_std} :
		sel_dly  ? {24'h0, luma_delay_reg} :
		sel_stat ? {24'h0, status_byte} :
		sel_bcs  ? {8'h0, saturation_gain, brightness_offset, contrast_gain} :
		sel_raw  ? {16'h0, raw_offset, raw_gain} :
		sel_oen  ? {24'h0, out_en} :
		sel_id   ? {24'h0, ID_VALUE} : 32'h0;
	// One wait cycle per access; waitrequest idles high
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata    <= 32'h0;
		end else begin
			o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
			o_avs_readdata    <= rd_mux;
		end
	end

	// Remodulation and luma separation
	logic signed [9:0] cb_i, cr_i, cb_d, cr_d;
	logic mux_ph;
	wire signed [9:0] cb_c = $signed({2'b00, i_in.cb}) - 10'sd128;
	wire signed [9:0] cr_c = $signed({2'b00, i_in.cr}) - 10'sd128;
	// Interpolation: averaging for wide notch, heavier smoothing for narrow
	wire signed [10:0] cb_sum = notch_width_select ? (11'(cb_c) + 11'(cb_d)) : (11'(cb_c) + 11'(cb_i));
	wire signed [10:0] cr_sum = notch_width_select ? (11'(cr_c) + 11'(cr_d)) : (11'(cr_c) + 11'(cr_i));
	wire signed [9:0] cb_interp = 10'(cb_sum >>> 1);
	wire signed [9:0] cr_interp = 10'(cr_sum >>> 1);
	// Subcarrier phases from the second oscillator; 60 Hz selects the NTSC delay tap
	wire [7:0] sub = std_60hz ? i_remod_sub1 : i_remod_sub0;
	wire signed [8:0] sub_s = $signed({1'b0, sub}) - 9'sd128;
	wire signed [9:0] mod_src = mux_ph ? cr_interp : cb_interp;
	wire signed [18:0] prod = 19'(mod_src) * 19'(sub_s);
	logic signed [10:0] remod, remod_prev;
	wire signed [10:0] remod_sum = 11'(prod >>> 7) + remod_prev;
	wire signed [11:0] y_sep = $signed({3'b000, i_in.cvbs}) - (luma_comb_enable ? 12'sd0 : 12'(remod));
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			cb_d <= 10'sd0; cr_d <= 10'sd0; cb_i <= 10'sd0; cr_i <= 10'sd0;
			mux_ph <= 1'b0; remod <= 11'sd0; remod_prev <= 11'sd0;
		end else if (i_in.valid) begin
			cb_d <= cb_c; cr_d <= cr_c; cb_i <= cb_interp; cr_i <= cr_interp;
			mux_ph <= !mux_ph;
			remod_prev <= 11'(prod >>> 7);
			remod <= remod_sum;
		end
	end

	// Peaking / low-pass filter and delay line
	logic signed [11:0] yd [0:7];
	wire signed [13:0] hp = 14'(y_sep) - 14'(yd[1]);
	wire signed [3:0] kf = $signed(luma_filter_select) ;
	wire signed [17:0] shp = 18'(hp) * 18'(kf);
	wire signed [13:0] y_filt = 14'(y_sep) + 14'(shp >>> 3);
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			for (int k = 0; k < 8; k++) yd[k] <= 12'sd0;
		end else if (i_in.valid) begin
			yd[0] <= 12'(y_filt);
			for (int k = 1; k < 8; k++) yd[k] <= yd[k-1];
		end
	end
	wire signed [11:0] y_del = yd[luma_delay_select];
	// 9-bit luma to 8-bit scale
	wire signed [11:0] y8 = y_del >>> 1;

	// Level equations, truncating toward zero then adding offset, then clipping
	function automatic logic [7:0] clip8(input logic signed [19:0] v);
		if (v < 20'sd1) clip8 = 8'(CLIP_MIN);
		else if (v > 20'sd254) clip8 = 8'(CLIP_MAX);
		else clip8 = v[7:0];
	endfunction
	wire signed [19:0] y_prod = 20'(12'(y8) - 12'sd128) * $signed({12'h0, contrast_gain});
	wire signed [19:0] y_q = y_prod / 20'sd68;
	wire signed [19:0] y_out = y_q + $signed({12'h0, brightness_offset});
	wire signed [19:0] cb_q = (20'(cb_c) * $signed({12'h0, saturation_gain})) / 20'sd64;
	wire signed [19:0] cr_q = (20'(cr_c) * $signed({12'h0, saturation_gain})) / 20'sd64;
	wire signed [19:0] raw_q = (20'($signed({3'b000, i_in.cvbs[8:1]})) - 20'sd128)
		* $signed({12'h0, raw_gain}) / 20'sd64;
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_out <= '0;
		end else begin
			o_out.valid <= i_in.valid && !soft_rst;
			if (i_in.valid) begin
				o_out.y   <= clip8(y_out);
				o_out.cb  <= clip8(cb_q + 20'sd128);
				o_out.cr  <= clip8(cr_q + 20'sd128);
				o_out.raw <= clip8(raw_q + $signed({12'h0, raw_offset}));
			end
		end
	end

	// Sync path: low-pass, slice, phase detect, loop filter, line oscillator
	logic [11:0] sync_lpf;
	logic        sliced, sliced_d;
	logic [8:0]  line_cnt;
	logic signed [11:0] loop_acc;
	logic [2:0]  pulse_cnt;
	wire [8:0] line_len = std_60hz ? 9'(LINE_60) : 9'(LINE_50);
	// Edge counted once per sample, not held while the stream pauses
	wire sync_edge = i_in.valid && sliced && !sliced_d;
	wire signed [11:0] phase_err = $signed({3'b000, line_cnt}) - $signed({3'b000, line_len >> 1});
	wire [8:0] line_end = 9'(line_len - 9'd1);
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			sync_lpf <= 12'h0; sliced <= 1'b0; sliced_d <= 1'b0;
			line_cnt <= 9'h0; loop_acc <= 12'sd0; pulse_cnt <= 3'h0;
			copy_protect_flag <= 1'b0; sync_locked <= 1'b0; o_line_freq_control <= 1'b0;
		end else if (soft_rst) begin
			line_cnt <= 9'h0; loop_acc <= 12'sd0; pulse_cnt <= 3'h0;
			copy_protect_flag <= 1'b0; sync_locked <= 1'b0;
		end else begin
			if (i_in.valid) begin
				sync_lpf <= sync_lpf - (sync_lpf >> SYNC_LPF_SH) + {7'h0, y_sep[8:4]};
				sliced   <= (sync_lpf[11:4] < SYNC_SLICE);
				sliced_d <= sliced;
			end
			if (ll4_rise) begin
				line_cnt <= (line_cnt >= line_end) ? 9'h0 : line_cnt + 9'h1;
				o_line_freq_control <= (line_cnt < (line_len >> 1));
				if (line_cnt >= line_end) begin
					copy_protect_flag <= (pulse_cnt >= 3'(PSEUDO_MIN));
					pulse_cnt <= 3'h0;
				end
			end
			if (sync_edge) begin
				loop_acc <= loop_acc + phase_err;
				sync_locked <= (phase_err < 12'sd4) && (phase_err > -12'sd4);
				if (pulse_cnt != 3'h7) pulse_cnt <= pulse_cnt + 3'h1;
			end
		end
	end

	// Output drivers and enables
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_line_locked_clock <= 1'b0; o_line_locked_half_clock <= 1'b0;
			o_clk_oe_n <= 1'b1; o_decoder_serial_data_oe_n <= 1'b1;
			o_out_oe_n <= 1'b1; o_reset_indicator_out <= 1'b0;
		end else begin
			o_line_locked_clock      <= llc_ph[0];
			o_line_locked_half_clock <= llc_ph[1];
			o_clk_oe_n <= soft_rst;
			o_decoder_serial_data_oe_n <= soft_rst;
			o_out_oe_n <= soft_rst || !out_en[0];
			o_reset_indicator_out <= (rs_state == RS_RUN);
		end
	end

	if (LLC_DIV < 2) begin : g_div_chk
		$error("clock too slow for divider");
	end

	// Checks
	default clocking cb_clk @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	reset_hiz_a: assert property (soft_rst |=> o_out_oe_n && o_clk_oe_n) else $error("outputs live in reset");
	ce_reset_a: assert property (!ce_sync[1] |=> soft_rst) else $error("enable low no reset");
	indicator_low_a: assert property ((rs_state == RS_HOLD) |=> !o_reset_indicator_out) else $error("indicator high early");
	enable_prog_a: assert property ((rs_state == RS_RUN && !out_en[0]) |=> o_out_oe_n) else $error("data enabled unprogrammed");
	clip_y_a: assert property (o_out.valid |-> o_out.y >= 8'h01 && o_out.y <= 8'hfe) else $error("luma not clipped");
	clip_c_a: assert property (o_out.valid |->
		o_out.cb inside {[8'h01:8'hfe]} && o_out.cr inside {[8'h01:8'hfe]})
		else $error("chroma not clipped");
	sat_default_a: assert property ((rs_state == RS_RESET) |=> saturation_gain == 8'h40 && contrast_gain == 8'h44) else $error("bad bcs default");
	raw_default_a: assert property ((rs_state == RS_RESET) |=> raw_gain == 8'h40 && raw_offset == 8'h80) else $error("bad raw default");
	line_wrap_a: assert property (line_cnt <= 9'd431) else $error("line counter overrun");
	bus_ack_a: assert property ($rose(i_avs_read) |-> ##1 !o_avs_waitrequest) else $error("no bus answer");
	run_cov_c: cover property (rs_state == RS_HOLD ##1 rs_state == RS_RUN);
	copy_protect_flag_cov_c: cover property ($rose(copy_protect_flag));
	clip_cov_c: cover property (o_out.valid && o_out.y == 8'hfe);
endmodule

// [vlb_pkg.sv]
package vlb_pkg;
	localparam int DW = 9;
	localparam int BW = 8;
	// Register offsets (byte addresses, word index times four)
	localparam logic [7:0] OFF_LUMA_CTRL  = 8'h24; // index 09h
	localparam logic [7:0] OFF_CHROMA_STD = 8'h38; // index 0eh
	localparam logic [7:0] OFF_LUMA_DELAY = 8'h44; // index 11h
	localparam logic [7:0] OFF_STATUS     = 8'h7c; // index 1fh
	localparam logic [7:0] OFF_BCS        = 8'h80; // own
	localparam logic [7:0] OFF_RAW        = 8'h84; // own
	localparam logic [7:0] OFF_OUT_EN     = 8'h88; // own
	localparam logic [7:0] OFF_ID         = 8'h8c; // own
	// Field positions
	localparam int POS_COMB    = 6;
	localparam int POS_NOTCH   = 4;
	localparam int POS_COPY_PROTECT_FLAG   = 2;
	localparam int POS_LOCK    = 0;
	// Reset values
	localparam logic [7:0] RST_CONTRAST   = 8'h44;
	localparam logic [7:0] RST_BRIGHT     = 8'h80;
	localparam logic [7:0] RST_SAT        = 8'h40;
	localparam logic [7:0] RST_RAW_GAIN   = 8'h40;
	localparam logic [7:0] RST_RAW_OFFSET = 8'h80;
	localparam logic [7:0] ID_VALUE       = 8'h5a; // Arbitrary value
	// Level constants
	localparam int CON_DIV  = 68;
	localparam int SAT_DIV  = 64;
	localparam int MID      = 128;
	localparam int CLIP_MIN = 1;
	localparam int CLIP_MAX = 254;
	// Timing
	localparam int CLK_MHZ      = 200;
	localparam int LLC_MHZ      = 27;
	localparam int LLC_DIV      = CLK_MHZ / LLC_MHZ;
	localparam int LINE_50      = 429;
	localparam int LINE_60      = 432;
	localparam int RESET_LLC    = 128;
	localparam int SYNC_LPF_SH  = 4;
	localparam logic [7:0] SYNC_SLICE = 8'h20;
	localparam int PSEUDO_MIN   = 3;
	typedef struct packed {
		logic [DW-1:0] cvbs;
		logic [BW-1:0] cb;
		logic [BW-1:0] cr;
		logic          valid;
	} vlb_in_t;
	typedef struct packed {
		logic [BW-1:0] y;
		logic [BW-1:0] cb;
		logic [BW-1:0] cr;
		logic [BW-1:0] raw;
		logic          valid;
	} vlb_out_t;
	typedef enum logic [1:0] {
		RS_RESET = 2'b00,
		RS_HOLD  = 2'b01,
		RS_RUN   = 2'b10
	} vlb_rst_state_t;
endpackage

// [vlb_sink.sv]
`timescale 1ns/100ps
module vlb_sink (
	input  wire logic              i_mclk,
	input  wire logic              i_rst,
	input  wire vlb_pkg::vlb_out_t i_out,
	input  wire logic              i_oe_n,
	output logic [31:0]            o_last,
	output int                     o_cnt
);
	import vlb_pkg::*;
	// Undriven outputs carry nothing the formatter may take
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_last <= '0;
			o_cnt  <= 0;
		end else if (i_out.valid === 1'b1 && i_oe_n === 1'b0) begin
			o_last <= {i_out.y, i_out.cb, i_out.cr, i_out.raw};
			o_cnt  <= o_cnt + 1;
		end
	end
endmodule
